// File: rtl/exec_unit_consts.vh
`ifndef EXEC_UNIT_CONSTS_VH
`define EXEC_UNIT_CONSTS_VH

// Register byte offsets
`define REG_OPA          8'h00
`define REG_OPB          8'h04
`define REG_OPC          8'h08
`define REG_CMD          8'h0C
`define REG_STATUS       8'h10
`define REG_RESULT       8'h14
`define REG_RESULT2      8'h18
`define REG_INFO         8'h1C
`define REG_PC           8'h20
`define REG_LOOP_COUNT   8'h24
`define REG_LOOP_END     8'h28
`define REG_ACCA_LO      8'h2C
`define REG_ACCA_HI      8'h30
`define REG_ACCB_LO      8'h34
`define REG_ACCB_HI      8'h38

// Command register fields
`define CMD_OP_HI        4
`define CMD_OP_LO        0
`define CMD_PARAM_HI     8
`define CMD_PARAM_LO     5
`define CMD_VARIANT      9
`define CMD_NEXT_TWO     10
`define CMD_SFR          11
`define CMD_DIRECT       12
`define CMD_DOUBLE       13

// Status register bit positions
`define ST_C             0
`define ST_Z             1
`define ST_OV            2
`define ST_N             3
`define ST_DC            4
`define ST_SFA           5
`define ST_SAB           6
`define ST_OAB           7
`define ST_SB            8
`define ST_SA            9
`define ST_OB            10
`define ST_OA            11
`define STATUS_RESET     12'h000

// Operation codes
`define OP_NOP           5'h00
`define OP_SKIP_ZERO     5'h01
`define OP_SKIP_ONE      5'h02
`define OP_PROBE_FORCE   5'h03
`define OP_CALL          5'h04
`define OP_JUMP          5'h05
`define OP_CMP           5'h06
`define OP_CMP_BORROW    5'h07
`define OP_CMP_ZERO      5'h08
`define OP_SKIP_EQ       5'h09
`define OP_SKIP_GT       5'h0A
`define OP_SKIP_LT       5'h0B
`define OP_SKIP_NE       5'h0C
`define OP_BR_EQ         5'h0D
`define OP_BR_GT         5'h0E
`define OP_BR_LT         5'h0F
`define OP_BR_NE         5'h10
`define OP_CTX_SWITCH    5'h11
`define OP_DEC_ADJUST    5'h12
`define OP_INT_HOLD      5'h13
`define OP_DIVIDE        5'h14
`define OP_FRAC_DIVIDE   5'h15
`define OP_HW_LOOP       5'h16
`define OP_DISTANCE      5'h17
`define OP_CHANGE_SCAN   5'h18
`define OP_ONE_SCAN_HIGH 5'h19
`define OP_ONE_SCAN_LOW  5'h1A
`define OP_SHIFT_RIGHT   5'h1B

// Timing in instruction cycles
`define OSC_PER_CYCLE    6'd2
`define CYC_BASE         5'd1
`define CYC_SKIP_ONE     5'd2
`define CYC_SKIP_TWO     5'd3
`define CYC_BRANCH       5'd5
`define CYC_FLOW         5'd4
`define CYC_CTX          5'd2
`define CYC_DIVIDE       5'd18
`define CYC_LOOP         5'd2

`endif

// File: rtl/cpu_exec_unit.v
// Functional notes
// - Bit skip ops: 1 cycle, 2/3 skipping, no flags
// - Test-then-set copies bit to C or its complement to Z, sets bit
// - Calls take 4 cycles, update frame flag
// - Compare sets C,DC,N,OV,Z from difference
// - Compare with borrow subtracts inverted carry
// - Compare against zero sets five flags
// - Compare-skip: 1 cycle, 2/3 skipping, no flags
// - Compare-branch: 1 cycle, 5 taken, no flags
// - Context switch from literal/register, 2 cycles
// - Decimal adjust touches only carry flag
// - Interrupt hold for 14-bit cycle count
// - Integer divides take 18 cycles, N,Z,C,OV
// - Fractional divide takes 18 cycles, N,Z,C,OV
// - Hardware loop count plus one, 2 cycles
// - Distance square into accumulator A or B, OA/SA or OB/SB flags
// - Bit scans write position, set only carry
// - Jumps take 4 cycles, flags unchanged
// - Shift by one sets C,N,OV,Z; multi N,Z
// - Outer register access adds one cycle
// - Instruction cycle equals two clock periods
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "exec_unit_consts.vh"

module cpu_exec_unit
(
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Register port
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  // Core state
  output wire        busy,
  output reg  [22:0] pc,
  output reg  [2:0]  context_sel,
  output wire        int_blocked,
  output wire        loop_active
);

  reg  [15:0] opa;
  reg  [15:0] opb;
  reg  [15:0] opc;
  reg  [13:0] cmd;
  reg  [11:0] status;
  reg  [15:0] result;
  reg  [15:0] result2;
  reg  [5:0]  remain;
  reg  [4:0]  last_cyc;
  reg         last_skip;
  reg         last_taken;
  reg         phase;
  reg  [13:0] hold_cnt;
  reg  [15:0] loop_cnt;
  reg  [22:0] loop_end;
  reg  [39:0] acc_a;
  reg  [39:0] acc_b;

  reg  [11:0] next_status;
  reg  [15:0] next_result;
  reg  [15:0] next_result2;
  reg  [22:0] next_pc;
  reg  [4:0]  next_cyc;
  reg         next_skip;
  reg         next_taken;
  reg  [2:0]  next_ctx;
  reg  [13:0] next_hold;
  reg  [15:0] next_loop_cnt;
  reg  [22:0] next_loop_end;
  reg  [39:0] next_acc_a;
  reg  [39:0] next_acc_b;

  wire [4:0]  op      = wdata[`CMD_OP_HI:`CMD_OP_LO];
  wire [3:0]  param   = wdata[`CMD_PARAM_HI:`CMD_PARAM_LO];
  wire        variant = wdata[`CMD_VARIANT];
  wire        start   = wr && (addr == `REG_CMD) && !busy;

  assign busy        = (remain != 6'd0);
  assign int_blocked = (hold_cnt != 14'd0);
  assign loop_active = (loop_cnt != 16'd0);

  // Position of the first one seen from the top, 1..16, 0 when none
  function [4:0] scan_high;
    input [15:0] v;
    integer i;
    begin
      scan_high = 5'd0;
      for (i = 0; i < 16; i = i + 1)
        if (v[i])
          scan_high = 5'd16 - i[4:0];
    end
  endfunction

  function [15:0] reverse16;
    input [15:0] v;
    integer i;
    begin
      reverse16 = 16'h0000;
      for (i = 0; i < 16; i = i + 1)
        reverse16[i] = v[15 - i];
    end
  endfunction

  // Subtractor shared by the three flag-setting compares
  reg  [15:0] sub_a;
  reg  [15:0] sub_b;
  reg         sub_cin;
  wire [16:0] sub_sum = {1'b0, sub_a} + {1'b0, ~sub_b} + {16'h0000, sub_cin};
  wire [4:0]  sub_nib = {1'b0, sub_a[3:0]} + {1'b0, ~sub_b[3:0]} + {4'h0, sub_cin};
  wire        sub_ov  = (sub_a[15] != sub_b[15]) && (sub_sum[15] != sub_a[15]);
  wire        a_eq    = (opa == opb);
  wire        a_gt    = ($signed(opa) > $signed(opb));
  wire        a_lt    = ($signed(opa) < $signed(opb));

  // Divider works on magnitudes, signs fixed up afterwards
  wire        div_frac = (op == `OP_FRAC_DIVIDE);
  wire        div_sgn  = variant || div_frac;
  wire [31:0] div_dvd  = div_frac ? {opa[15], opa, 15'h0000} :
                         wdata[`CMD_DOUBLE] ? {opc, opa} :
                         (variant ? {{16{opa[15]}}, opa} : {16'h0000, opa});
  wire        dvd_neg  = div_sgn && div_dvd[31];
  wire        dvs_neg  = div_sgn && opb[15];
  wire [31:0] mag_dvd  = dvd_neg ? (32'h0000_0000 - div_dvd) : div_dvd;
  wire [15:0] mag_dvs  = dvs_neg ? (16'h0000 - opb) : opb;
  wire        dvs_zero = (opb == 16'h0000);
  wire [31:0] uq       = dvs_zero ? 32'hFFFF_FFFF : mag_dvd / {16'h0000, mag_dvs};
  wire [31:0] ur       = dvs_zero ? 32'h0000_0000 : mag_dvd % {16'h0000, mag_dvs};
  wire [31:0] sq_q     = (dvd_neg ^ dvs_neg) ? (32'h0000_0000 - uq) : uq;
  wire [31:0] sq_r     = dvd_neg ? (32'h0000_0000 - ur) : ur;
  wire        q_ovf    = dvs_zero ||
                         (div_sgn ? !((&sq_q[31:15]) || !(|sq_q[31:15])) : (|uq[31:16]));

  // Squared difference with saturation at the accumulator edge
  wire [16:0] ed_diff = {opa[15], opa} - {opb[15], opb};
  wire [33:0] ed_sq   = $signed(ed_diff) * $signed(ed_diff);
  wire [39:0] ed_acc  = param[0] ? acc_b : acc_a;
  wire [40:0] ed_sum  = (variant ? {ed_acc[39], ed_acc} : 41'h0) + {7'h00, ed_sq};
  wire        ed_sat  = (ed_sum[40] != ed_sum[39]);
  wire [39:0] ed_res  = ed_sat ? (ed_sum[40] ? 40'h80_0000_0000 : 40'h7F_FFFF_FFFF)
                               : ed_sum[39:0];
  wire        ed_ovf  = !((&ed_res[39:31]) || !(|ed_res[39:31]));

  // Decimal adjust of the low byte
  wire        daw_lo  = (opa[3:0] > 4'h9) || status[`ST_DC];
  wire [8:0]  daw_s1  = {1'b0, opa[7:0]} + (daw_lo ? 9'h006 : 9'h000);
  wire        daw_hi  = (daw_s1[7:4] > 4'h9) || status[`ST_C] || daw_s1[8];
  wire [8:0]  daw_s2  = daw_s1 + (daw_hi ? 9'h060 : 9'h000);

  wire [15:0] bit_mask = 16'h0001 << param;
  wire        bit_val  = |(opa & bit_mask);
  wire [1:0]  skip_cost_words = wdata[`CMD_NEXT_TWO] ? 2'd2 : 2'd1;
  wire [22:0] br_target = pc + 23'd1 + {{7{opc[15]}}, opc};
  wire [22:0] far_target = {opb[6:0], opa};
  wire [15:0] change_vec = {1'b0, opa[15:1] ^ opa[14:0]};
  wire [15:0] shifted    = opa >> param;

  // Execute one operation; results are committed on the starting edge
  always @*
  begin
    next_status   = status;
    next_result   = result;
    next_result2  = result2;
    next_pc       = pc + 23'd1;
    next_cyc      = `CYC_BASE;
    next_skip     = 1'b0;
    next_taken    = 1'b0;
    next_ctx      = context_sel;
    next_hold     = hold_cnt;
    next_loop_cnt = loop_cnt;
    next_loop_end = loop_end;
    next_acc_a    = acc_a;
    next_acc_b    = acc_b;
    sub_a         = opa;
    sub_b         = opb;
    sub_cin       = 1'b1;
    if (op == `OP_CMP_ZERO)
      sub_b = 16'h0000;
    else if (op == `OP_CMP_BORROW)
      sub_cin = status[`ST_C];
    case (op)
      `OP_SKIP_ZERO, `OP_SKIP_ONE, `OP_SKIP_EQ, `OP_SKIP_GT, `OP_SKIP_LT, `OP_SKIP_NE:
      begin
        if (op == `OP_SKIP_ZERO)
          next_skip = !bit_val;
        else if (op == `OP_SKIP_ONE)
          next_skip = bit_val;
        else if (op == `OP_SKIP_EQ)
          next_skip = a_eq;
        else if (op == `OP_SKIP_GT)
          next_skip = a_gt;
        else if (op == `OP_SKIP_LT)
          next_skip = a_lt;
        else
          next_skip = !a_eq;
        if (next_skip)
        begin
          next_cyc = wdata[`CMD_NEXT_TWO] ? `CYC_SKIP_TWO : `CYC_SKIP_ONE;
          next_pc  = pc + 23'd1 + {21'd0, skip_cost_words};
        end
      end
      `OP_PROBE_FORCE:
      begin
        if (variant)
          next_status[`ST_Z] = !bit_val;
        else
          next_status[`ST_C] = bit_val;
        next_result = opa | bit_mask;
      end
      `OP_CALL, `OP_JUMP:
      begin
        // four cycles, one or two words
        next_cyc = `CYC_FLOW;
        next_pc  = (wdata[`CMD_DIRECT] || variant) ? far_target : {7'h00, opa};
        if (op == `OP_CALL)
          next_status[`ST_SFA] = 1'b0;
      end
      `OP_CMP, `OP_CMP_BORROW, `OP_CMP_ZERO:
      begin
        next_status[`ST_C]  = sub_sum[16];
        next_status[`ST_DC] = sub_nib[4];
        next_status[`ST_N]  = sub_sum[15];
        next_status[`ST_OV] = sub_ov;
        next_status[`ST_Z]  = (sub_sum[15:0] == 16'h0000);
      end
      `OP_BR_EQ, `OP_BR_GT, `OP_BR_LT, `OP_BR_NE:
      begin
        if (op == `OP_BR_EQ)
          next_taken = a_eq;
        else if (op == `OP_BR_GT)
          next_taken = a_gt;
        else if (op == `OP_BR_LT)
          next_taken = a_lt;
        else
          next_taken = !a_eq;
        if (next_taken)
        begin
          next_cyc = `CYC_BRANCH;
          next_pc  = br_target;
        end
      end
      `OP_CTX_SWITCH:
      begin
        next_cyc = `CYC_CTX;
        next_ctx = variant ? opa[2:0] : param[2:0];
      end
      `OP_DEC_ADJUST:
      begin
        next_result        = {opa[15:8], daw_s2[7:0]};
        next_status[`ST_C] = status[`ST_C] | daw_s1[8] | daw_s2[8];
      end
      `OP_INT_HOLD:
        next_hold = opa[13:0];
      `OP_DIVIDE, `OP_FRAC_DIVIDE:
      begin
        next_cyc            = `CYC_DIVIDE;
        next_result         = sq_q[15:0];
        next_result2        = sq_r[15:0];
        next_status[`ST_N]  = sq_q[15];
        next_status[`ST_Z]  = (sq_q[15:0] == 16'h0000);
        next_status[`ST_C]  = (sq_r[15:0] != 16'h0000);
        next_status[`ST_OV] = q_ovf;
      end
      `OP_HW_LOOP:
      begin
        next_cyc      = `CYC_LOOP;
        next_pc       = pc + 23'd2;
        next_loop_cnt = {1'b0, opa[14:0]} + 16'h0001;
        next_loop_end = pc + 23'd2 + {{7{opc[15]}}, opc};
      end
      `OP_DISTANCE:
      begin
        if (param[0])
        begin
          next_acc_b          = ed_res;
          next_status[`ST_OB] = ed_ovf;
          next_status[`ST_SB] = ed_sat;
        end
        else
        begin
          next_acc_a          = ed_res;
          next_status[`ST_OA] = ed_ovf;
          next_status[`ST_SA] = ed_sat;
        end
        next_status[`ST_OAB] = next_status[`ST_OA] | next_status[`ST_OB];
        next_status[`ST_SAB] = next_status[`ST_SA] | next_status[`ST_SB];
      end
      `OP_CHANGE_SCAN, `OP_ONE_SCAN_HIGH, `OP_ONE_SCAN_LOW:
      begin
        if (op == `OP_CHANGE_SCAN)
          next_result = {11'h000, scan_high(change_vec)};
        else if (op == `OP_ONE_SCAN_HIGH)
          next_result = {11'h000, scan_high(opa)};
        else
          next_result = {11'h000, scan_high(reverse16(opa))};
        next_status[`ST_C] = (next_result == 16'h0000);
      end
      `OP_SHIFT_RIGHT:
      begin
        if (variant)
        begin
          next_result        = shifted;
          next_status[`ST_N] = shifted[15];
          next_status[`ST_Z] = (shifted == 16'h0000);
        end
        else
        begin
          next_result         = {1'b0, opa[15:1]};
          next_status[`ST_C]  = opa[0];
          next_status[`ST_N]  = 1'b0;
          next_status[`ST_OV] = 1'b0;
          next_status[`ST_Z]  = (opa[15:1] == 15'h0000);
        end
      end
      default:
        next_cyc = `CYC_BASE;
    endcase
    if (wdata[`CMD_SFR])
      next_cyc = next_cyc + 5'd1;
  end

  // Register writes and instruction launch
  always @(posedge clk)
  begin
    if (reset)
    begin
      opa         <= 16'h0000;
      opb         <= 16'h0000;
      opc         <= 16'h0000;
      cmd         <= 14'h0000;
      status      <= `STATUS_RESET;
      result      <= 16'h0000;
      result2     <= 16'h0000;
      pc          <= 23'h000000;
      context_sel <= 3'h0;
      loop_cnt    <= 16'h0000;
      loop_end    <= 23'h000000;
      acc_a       <= 40'h00_0000_0000;
      acc_b       <= 40'h00_0000_0000;
      last_cyc    <= 5'h00;
      last_skip   <= 1'b0;
      last_taken  <= 1'b0;
    end
    else if (start)
    begin
      cmd         <= wdata[13:0];
      status      <= next_status;
      result      <= next_result;
      result2     <= next_result2;
      pc          <= next_pc;
      context_sel <= next_ctx;
      loop_cnt    <= next_loop_cnt;
      loop_end    <= next_loop_end;
      acc_a       <= next_acc_a;
      acc_b       <= next_acc_b;
      last_cyc    <= next_cyc;
      last_skip   <= next_skip;
      last_taken  <= next_taken;
    end
    else if (wr)
    begin
      if (addr == `REG_OPA)
        opa <= wdata[15:0];
      else if (addr == `REG_OPB)
        opb <= wdata[15:0];
      else if (addr == `REG_OPC)
        opc <= wdata[15:0];
      else if (addr == `REG_STATUS)
        status <= wdata[11:0];
      else if (addr == `REG_PC)
        pc <= wdata[22:0];
    end
  end

  // busy spans two clocks per instruction cycle
  always @(posedge clk)
  begin
    if (reset)
      remain <= 6'd0;
    else if (start)
      remain <= {1'b0, next_cyc} * `OSC_PER_CYCLE;
    else if (busy)
      remain <= remain - 6'd1;
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      phase    <= 1'b0;
      hold_cnt <= 14'h0000;
    end
    else
    begin
      phase <= ~phase;
      if (start && (op == `OP_INT_HOLD))
        hold_cnt <= next_hold;
      else if (phase && int_blocked)
        hold_cnt <= hold_cnt - 14'd1;
    end
  end

  // Read data, valid the cycle after the strobe only
  always @(posedge clk)
  begin
    if (reset || !rd)
      rdata <= 32'h0000_0000;
    else if (addr == `REG_OPA)
      rdata <= {16'h0000, opa};
    else if (addr == `REG_OPB)
      rdata <= {16'h0000, opb};
    else if (addr == `REG_OPC)
      rdata <= {16'h0000, opc};
    else if (addr == `REG_CMD)
      rdata <= {18'h00000, cmd};
    else if (addr == `REG_STATUS)
      rdata <= {20'h00000, status};
    else if (addr == `REG_RESULT)
      rdata <= {16'h0000, result};
    else if (addr == `REG_RESULT2)
      rdata <= {16'h0000, result2};
    else if (addr == `REG_INFO)
      rdata <= {2'b00, hold_cnt, 3'b000, last_cyc, loop_active, int_blocked,
                context_sel, last_taken, last_skip, busy};
    else if (addr == `REG_PC)
      rdata <= {9'h000, pc};
    else if (addr == `REG_LOOP_COUNT)
      rdata <= {16'h0000, loop_cnt};
    else if (addr == `REG_LOOP_END)
      rdata <= {9'h000, loop_end};
    else if (addr == `REG_ACCA_LO)
      rdata <= acc_a[31:0];
    else if (addr == `REG_ACCA_HI)
      rdata <= {24'h000000, acc_a[39:32]};
    else if (addr == `REG_ACCB_LO)
      rdata <= acc_b[31:0];
    else if (addr == `REG_ACCB_HI)
      rdata <= {24'h000000, acc_b[39:32]};
    else
      rdata <= 32'h0000_0000;
  end

endmodule // cpu_exec_unit

// File: sim/cpu_exec_unit_chk.sv
`timescale 1ns/1ps
`include "exec_unit_consts.vh"

module cpu_exec_unit_chk
(
  // Clock and reset
  input wire        clk,
  input wire        reset,
  // Register port
  input wire [7:0]  addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [31:0] rdata,
  // Core state
  input wire        busy,
  input wire [22:0] pc,
  input wire [2:0]  context_sel,
  input wire        int_blocked,
  input wire        loop_active
);
  reg  [15:0] opa;
  // Launch decode; the outer access bit adds a cycle, so plain counts exclude it
  wire        go   = wr && !busy && addr == `REG_CMD;
  wire [4:0]  op   = wdata[4:0];
  wire        flat = !wdata[`CMD_SFR];
  wire        hit  = (op == `OP_SKIP_ONE) == opa[wdata[8:5]];
  wire [22:0] step = !hit ? 23'h000001 :
                     wdata[`CMD_NEXT_TWO] ? 23'h000003 : 23'h000002;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Operand shadow, needed to predict skips and the hold flag
  always @(posedge clk)
    if (reset)
      opa <= 16'h0000;
    else if (wr && addr == `REG_OPA)
      opa <= wdata[15:0];

  a_base_two_clocks:
    assert property (go && op == `OP_CMP && flat |=> busy [*2] ##1 !busy)
    else $error("one-cycle op busy length wrong");
  a_outer_extra:
    assert property (go && op == `OP_CMP && !flat |=> busy [*4] ##1 !busy)
    else $error("outer access did not add a cycle");
  a_flow_eight:
    assert property (go && (op == `OP_CALL || op == `OP_JUMP) && flat
                     |=> busy [*8] ##1 !busy)
    else $error("call or jump busy length wrong");
  a_divide_span:
    assert property (go && (op == `OP_DIVIDE || op == `OP_FRAC_DIVIDE) && flat
                     |-> ##1 busy ##35 busy ##1 !busy)
    else $error("divide busy length wrong");
  a_ctx_literal:
    assert property (go && op == `OP_CTX_SWITCH && !wdata[`CMD_VARIANT] && flat
                     |=> context_sel == $past(wdata[7:5]) ##0 busy [*4] ##1 !busy)
    else $error("context switch wrong");
  a_hold_start:
    assert property (go && op == `OP_INT_HOLD |=> int_blocked == (opa[13:0] != 14'h0000))
    else $error("hold flag wrong after launch");
  a_loop_start:
    assert property (go && op == `OP_HW_LOOP && flat |=> loop_active ##0 busy [*4] ##1 !busy)
    else $error("loop launch wrong");
  a_skip_step:
    assert property (go && (op == `OP_SKIP_ZERO || op == `OP_SKIP_ONE)
                     |=> pc == $past(pc) + $past(step))
    else $error("bit skip pc step wrong");

  // Main scenarios reached
  c_divide: cover property (go && op == `OP_DIVIDE);
  c_branch: cover property (go && op == `OP_BR_LT);
  c_skip_two: cover property (go && op == `OP_SKIP_ONE && wdata[`CMD_NEXT_TWO]);
endmodule // cpu_exec_unit_chk

bind cpu_exec_unit cpu_exec_unit_chk cpu_exec_unit_chk_inst (
  .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .busy(busy), .pc(pc), .context_sel(context_sel),
  .int_blocked(int_blocked), .loop_active(loop_active)
);

// File: sim/cpu_exec_unit_tb.sv
`timescale 1ns/1ps
`include "exec_unit_consts.vh"

module cpu_exec_unit_tb;
  reg         clk, reset, wr, rd;
  reg  [7:0]  addr;
  reg  [31:0] wdata, d;
  wire [31:0] rdata;
  wire        busy, int_blocked, loop_active;
  wire [22:0] pc;
  wire [2:0]  context_sel;
  reg  [22:0] p0;
  integer     error_cnt, n_tests, n, i;

  cpu_exec_unit cpu_exec_unit_inst (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .busy(busy), .pc(pc), .context_sel(context_sel),
    .int_blocked(int_blocked), .loop_active(loop_active)
  );

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  // Bus cycles; a gap cycle keeps each strobe to one assignment per step
  task put(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
    end
  endtask

  task get(input [7:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
    end
  endtask

  // Counts busy clocks after a launch, bounded so a hang ends the run
  task idle;
    begin
      n = 0;
      #1;
      while (busy !== 1'b0 && n < 100)
      begin
        @(posedge clk);
        #1 n = n + 1;
      end
      if (n >= 100)
      begin
        error_cnt = error_cnt + 1;
        tally_and_finish;
      end
    end
  endtask

  task run(input [31:0] c, input integer cy);
    begin
      put(`REG_CMD, c);
      idle;
      chk("clocks", 2 * cy, n);
    end
  endtask

  task flow(input [31:0] c, input integer cy, input integer st);
    begin
      p0 = pc;
      run(c, cy);
      chk("pc", {9'h000, p0 + st[22:0]}, {9'h000, pc});
    end
  endtask

  task setops(input [15:0] a, input [15:0] b, input [15:0] c, input [11:0] s);
    begin
      put(`REG_OPA, a);
      put(`REG_OPB, b);
      put(`REG_OPC, c);
      put(`REG_STATUS, s);
    end
  endtask

  // Launch, then compare status and the untouched operand
  task fcase(input [31:0] c, input [15:0] a, input [15:0] b, input [11:0] s0, s1);
    begin
      setops(a, b, 16'h0000, s0);
      put(`REG_CMD, c);
      idle;
      get(`REG_STATUS);
      chk("status", s1, d);
      get(`REG_OPA);
      chk("opa", a, d);
    end
  endtask

  // Fixed-length instruction-cycle counts
  function integer ncyc(input [4:0] o);
    case (o)
      `OP_CALL, `OP_JUMP: ncyc = 4;
      `OP_CTX_SWITCH, `OP_HW_LOOP: ncyc = 2;
      `OP_DIVIDE, `OP_FRAC_DIVIDE: ncyc = 18;
      default: ncyc = 1;
    endcase
  endfunction

  task t_reset;
    begin
      get(`REG_STATUS);
      chk("status", 32'h00000000, d);
      get(8'h3C);
      chk("unmapped", 32'h00000000, d);
      chk("pc", 32'h00000000, {9'h000, pc});
    end
  endtask

  // Every fixed-length op except the no-op, plain and with the outer access bit
  task t_timing;
    integer s;
    begin
      setops(16'h0003, 16'h0001, 16'h0000, 12'h000);
      for (s = 0; s < 2; s = s + 1)
        for (i = 3; i < 28; i = i + 1)
          if (i < 9 || i > 16)
            run(i | (s << 11), ncyc(i[4:0]) + s);
    end
  endtask

  task t_flags;
    begin
      fcase(`OP_CMP, 16'h0005, 16'h0007, 12'h000, 12'h008);
      fcase(`OP_CMP_BORROW, 16'h0007, 16'h0005, 12'h000, 12'h011);
      fcase(`OP_CMP_ZERO, 16'h0000, 16'h0000, 12'h008, 12'h013);
      fcase(`OP_DIVIDE, 16'h0064, 16'h0007, 12'h000, 12'h001);
      get(`REG_RESULT);
      chk("quot", 32'h0000000E, d);
      get(`REG_RESULT2);
      chk("rem", 32'h00000002, d);
      fcase(`OP_SHIFT_RIGHT, 16'h0001, 16'h0000, 12'h000, 12'h003);
      fcase(`OP_SHIFT_RIGHT | 12'h280, 16'h8000, 16'h0000, 12'h005, 12'h005);
      get(`REG_RESULT);
      chk("shift", 32'h00000800, d);
      fcase(`OP_DEC_ADJUST, 16'h009A, 16'h0000, 12'h00E, 12'h00F);
      get(`REG_RESULT);
      chk("bcd", 32'h00000000, d & 32'h000000FF);
      fcase(`OP_PROBE_FORCE | 12'h060, 16'h0000, 16'h0000, 12'h001, 12'h000);
      get(`REG_RESULT);
      chk("set", 32'h00000008, d);
      fcase(`OP_PROBE_FORCE | 12'h260, 16'h0008, 16'h0000, 12'h002, 12'h000);
      fcase(`OP_ONE_SCAN_HIGH, 16'h0000, 16'h0000, 12'h00E, 12'h00F);
      fcase(`OP_FRAC_DIVIDE, 16'h2000, 16'h4000, 12'h000, 12'h000);
      get(`REG_RESULT);
      chk("fquot", 32'h00004000, d);
      fcase(`OP_DISTANCE, 16'h8000, 16'h7FFF, 12'h000, 12'h880);
      get(`REG_ACCA_LO);
      chk("acc", 32'hFFFE0001, d);
      fcase(`OP_DISTANCE | 12'h200, 16'h0003, 16'h0001, 12'h000, 12'h880);
      get(`REG_ACCA_LO);
      chk("acc", 32'hFFFE0005, d);
      fcase(`OP_CALL, 16'h0000, 16'h0000, 12'h020, 12'h000);
    end
  endtask

  // Skips and branches; signed operands so greater and less differ from unsigned
  task t_skip;
    integer t;
    begin
      setops(16'h0010, 16'h0000, 16'h0000, 12'h01F);
      flow(`OP_SKIP_ZERO | 12'h080, 1, 1);
      flow(`OP_SKIP_ONE | 12'h080, 2, 2);
      flow(`OP_SKIP_ONE | 12'h480, 3, 3);
      setops(16'hFFFF, 16'h0001, 16'h0010, 12'h01F);
      for (i = 9; i < 17; i = i + 1)
      begin
        t = (i % 4 == 3 || i % 4 == 0);
        flow(i, !t ? 1 : i < 13 ? 2 : 5, !t ? 1 : i < 13 ? 2 : 17);
      end
      get(`REG_STATUS);
      chk("status", 32'h0000001F, d);
    end
  endtask

  // Context, a launch refused while busy, hold and loop
  task t_state;
    begin
      run(`OP_CTX_SWITCH | 12'h0A0, 2);
      chk("ctx", 32'h00000005, context_sel);
      put(`REG_OPA, 32'h00000006);
      run(`OP_CTX_SWITCH | 12'h200, 2);
      chk("ctx", 32'h00000006, context_sel);
      put(`REG_CMD, `OP_DIVIDE);
      put(`REG_CMD, `OP_CTX_SWITCH | 12'h0E0);
      idle;
      chk("ctx", 32'h00000006, context_sel);
      put(`REG_OPA, 32'h00000003);
      run(`OP_INT_HOLD, 1);
      chk("hold", 32'h00000001, int_blocked);
      repeat (8) @(posedge clk);
      #1 chk("hold", 32'h00000000, int_blocked);
      flow(`OP_HW_LOOP, 2, 2);
      chk("loop", 32'h00000001, loop_active);
      get(`REG_LOOP_COUNT);
      chk("count", 32'h00000004, d);
      get(`REG_LOOP_END);
      chk("end", {9'h000, p0 + 23'h000012}, d);
    end
  endtask

  // Main sequence
  initial
  begin
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h00000000;
    d = 32'h00000000;
    p0 = 23'h000000;
    error_cnt = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_timing;
    t_flags;
    t_skip;
    t_state;
    tally_and_finish;
  end
endmodule // cpu_exec_unit_tb
